// [pkg/ltim_regs.svh]
// register offsets, field positions and reset values of the line-trap interrupt mask logic
`ifndef LTIM_REGS_SVH
`define LTIM_REGS_SVH

`define LTIM_ADDR_W          8
`define LTIM_OFS_RAW_STATUS  8'h00
`define LTIM_OFS_MASK_STATUS 8'h04
`define LTIM_OFS_ENABLE_SET  8'h08
`define LTIM_OFS_ENABLE_CLR  8'h0c
`define LTIM_TRAP_BIT        2
`define LTIM_RST_ENABLE      1'h0
`define LTIM_RST_STATUS      1'h0
`define LTIM_RST_RDATA       32'h0000_0000

`endif

// [pkg/ltim_pkg.sv]
// types shared by the line-trap interrupt mask logic
package ltim_pkg;

   typedef enum logic [1:0] {
      LTIM_MODE_LINEAR = 2'h0,
      LTIM_MODE_WRAP   = 2'h1,
      LTIM_MODE_FIXED  = 2'h2,
      LTIM_MODE_OTHER  = 2'h3
   } ltim_mode_type;

   typedef enum logic [3:0] {
      LTIM_REG_RAW  = 4'h1,
      LTIM_REG_MASK = 4'h2,
      LTIM_REG_SET  = 4'h4,
      LTIM_REG_CLR  = 4'h8
   } ltim_reg_type;

endpackage

// [logic/ltim_sticky_flag.sv]
// sticky status flag: hardware set wins over software clear
`timescale 1ns/1ps
`include "ltim_regs.svh"
module ltim_sticky_flag (
   input  wire logic clock,
   input  wire logic rstn,
   input  wire logic setPulse,
   input  wire logic clrPulse,
   output logic      flag
);

   logic flag_r;
   logic flag_nxt;

   always_comb begin
      flag_nxt = flag_r;
      if (clrPulse) begin
         flag_nxt = 1'b0;
      end
      if (setPulse) begin
         flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         flag_r <= `LTIM_RST_STATUS;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   assign flag = flag_r;

endmodule // ltim_sticky_flag

// [logic/ltim_line_trap_irq.sv]
// line-trap interrupt enable set/clear, raw and masked status, register port
//
// Functional notes
// - set-register bit2 write one enables interrupt
// - simultaneous set and clear leaves interrupt disabled
// - clear-register bit2 write one disables interrupt
// - both registers read bit2 as enable
// - unsupported addressing mode sets raw status
// - masked status set only while enabled
// - writing one to either status clears both
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "ltim_regs.svh"
module ltim_line_trap_irq (
   input  wire logic                      clock,
   input  wire logic                      rstn,
   input  wire logic [`LTIM_ADDR_W-1:0]   regAddr,
   input  wire logic [31:0]               regWrData,
   input  wire logic                      regWrStrobe,
   input  wire logic                      regRdStrobe,
   output logic      [31:0]               regRdData,
   input  wire logic                      accessValid,
   input  wire ltim_pkg::ltim_mode_type   accessMode,
   output logic                           trapIrq
);

   //----------------------------------------
   // address decode
   //----------------------------------------
   function automatic logic [3:0] decodeReg(input logic [`LTIM_ADDR_W-1:0] a);
      logic [3:0] sel;
      sel = 4'h0;
      case (a)
         `LTIM_OFS_RAW_STATUS:  sel = ltim_pkg::LTIM_REG_RAW;
         `LTIM_OFS_MASK_STATUS: sel = ltim_pkg::LTIM_REG_MASK;
         `LTIM_OFS_ENABLE_SET:  sel = ltim_pkg::LTIM_REG_SET;
         `LTIM_OFS_ENABLE_CLR:  sel = ltim_pkg::LTIM_REG_CLR;
         default:               sel = 4'h0;
      endcase
      return sel;
   endfunction

   logic [3:0] wrSel;
   logic [3:0] rdSel;
   logic       wrBit;

   assign wrSel = regWrStrobe ? decodeReg(regAddr) : 4'h0;
   assign rdSel = regRdStrobe ? decodeReg(regAddr) : 4'h0;
   // only the trap bit acts; reserved bits are dropped here
   assign wrBit = regWrData[`LTIM_TRAP_BIT];

   //----------------------------------------
   // write-one strobes, one per register
   //----------------------------------------
   logic [3:0] wrOneSel;

   // a write moves state only where the trap bit is one
   generate
      for (genvar i = 0; i < 4; i++) begin : g_wr_one
         assign wrOneSel[i] = wrSel[i] & wrBit;
      end
   endgenerate

   //----------------------------------------
   // addressing mode check
   //----------------------------------------
   // only linear increment and line wrap are legal
   function automatic logic isTrapMode(input ltim_pkg::ltim_mode_type m);
      logic trapMode;
      trapMode = 1'b1;
      case (m)
         ltim_pkg::LTIM_MODE_LINEAR: trapMode = 1'b0;
         ltim_pkg::LTIM_MODE_WRAP:   trapMode = 1'b0;
         default:                    trapMode = 1'b1;
      endcase
      return trapMode;
   endfunction

   //----------------------------------------
   // register read view
   //----------------------------------------
   // reserved bits always read zero
   function automatic logic [31:0] readView(
      input logic [3:0] sel,
      input logic       raw,
      input logic       masked,
      input logic       en
   );
      logic [31:0] word;
      word = `LTIM_RST_RDATA;
      case (sel)
         ltim_pkg::LTIM_REG_RAW:  word[`LTIM_TRAP_BIT] = raw;
         ltim_pkg::LTIM_REG_MASK: word[`LTIM_TRAP_BIT] = masked;
         ltim_pkg::LTIM_REG_SET:  word[`LTIM_TRAP_BIT] = en;
         ltim_pkg::LTIM_REG_CLR:  word[`LTIM_TRAP_BIT] = en;
         default:                 word = `LTIM_RST_RDATA;
      endcase
      return word;
   endfunction

   //----------------------------------------
   // interrupt enable
   //----------------------------------------
   logic       enable_r;
   logic       enable_nxt;
   logic       setReq;
   logic       clrReq;
   logic [1:0] enableReq;

   assign setReq    = wrOneSel[2];
   assign clrReq    = wrOneSel[3];
   assign enableReq = {setReq, clrReq};

   always_comb begin
      enable_nxt = enable_r;
      case (enableReq)
         2'b10: begin
            enable_nxt = 1'b1;
         end
         2'b01: begin
            enable_nxt = 1'b0;
         end
         // both at once: ends disabled, neither bit set
         2'b11: begin
            enable_nxt = 1'b0;
         end
         default: begin
            enable_nxt = enable_r;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         enable_r <= `LTIM_RST_ENABLE;
      end else begin
         enable_r <= enable_nxt;
      end
   end

   //----------------------------------------
   // trap detection
   //----------------------------------------
   logic trapEvent;
   logic maskedSet;
   logic statusClr;

   assign trapEvent = accessValid & isTrapMode(accessMode);
   // masking uses the registered enable, one cycle behind the write
   assign maskedSet = trapEvent & enable_r;
   assign statusClr = wrOneSel[0] | wrOneSel[1];

   //----------------------------------------
   // status flags
   //----------------------------------------
   logic rawStatus;
   logic maskedStatus;

   // a trap beside a clearing write leaves the flag set
   ltim_sticky_flag u_raw_flag (
      .clock    (clock),
      .rstn     (rstn),
      .setPulse (trapEvent),
      .clrPulse (statusClr),
      .flag     (rawStatus)
   );

   ltim_sticky_flag u_masked_flag (
      .clock    (clock),
      .rstn     (rstn),
      .setPulse (maskedSet),
      .clrPulse (statusClr),
      .flag     (maskedStatus)
   );

   //----------------------------------------
   // read data
   //----------------------------------------
   logic [31:0] rdData_r;
   logic [31:0] rdData_nxt;

   // no strobe selects nothing, so the port idles at zero
   always_comb begin
      rdData_nxt = readView(rdSel, rawStatus, maskedStatus, enable_r);
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         rdData_r <= `LTIM_RST_RDATA;
      end else begin
         rdData_r <= rdData_nxt;
      end
   end

   //----------------------------------------
   // interrupt output
   //----------------------------------------
   logic irq_r;
   logic irq_nxt;
   logic maskedNext;

   // mirrors the masked flag's next value so the pin needs no extra cycle
   assign maskedNext = maskedSet | (maskedStatus & ~statusClr);

   // level output, held until software clears the status
   always_comb begin
      irq_nxt = maskedNext;
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         irq_r <= `LTIM_RST_STATUS;
      end else begin
         irq_r <= irq_nxt;
      end
   end

   assign regRdData = rdData_r;
   assign trapIrq   = irq_r;

endmodule // ltim_line_trap_irq

// [test/ltim_irq_properties.sv]
// port assertions for the line-trap interrupt block
`timescale 1ns/1ps
`include "ltim_regs.svh"
module ltim_irq_properties (
   input wire logic                    clock,
   input wire logic                    rstn,
   input wire logic [`LTIM_ADDR_W-1:0] regAddr,
   input wire logic [31:0]             regWrData,
   input wire logic                    regWrStrobe,
   input wire logic                    regRdStrobe,
   input wire logic [31:0]             regRdData,
   input wire logic                    accessValid,
   input wire ltim_pkg::ltim_mode_type accessMode,
   input wire logic                    trapIrq
);
   default clocking dc @(posedge clock); endclocking
   default disable iff (!rstn);
   wire logic trap = accessValid && accessMode[1];
   wire logic wSet = regWrStrobe && regAddr == `LTIM_OFS_ENABLE_SET && regWrData[2];
   wire logic wClr = regWrStrobe && regAddr == `LTIM_OFS_ENABLE_CLR && regWrData[2];
   wire logic wSts = regWrStrobe && regWrData[2] && (regAddr == 8'h00 || regAddr == 8'h04);
   wire logic rSet = regRdStrobe && regAddr == `LTIM_OFS_ENABLE_SET;
   wire logic rClr = regRdStrobe && regAddr == `LTIM_OFS_ENABLE_CLR;
   wire logic rRaw = regRdStrobe && regAddr == `LTIM_OFS_RAW_STATUS;
   a_rd_idle: assert property (!regRdStrobe |=> regRdData == 32'h0) else $error("read data not idle");
   a_rsv_zero: assert property (regRdStrobe |=> regRdData[31:3] == 29'h0 && regRdData[1:0] == 2'h0)
      else $error("reserved bits set");
   a_set_visible: assert property (wSet ##1 !wClr ##1 rClr |=> regRdData[2]) else $error("set lost");
   a_clr_visible: assert property (wClr ##1 !wSet ##1 rSet |=> !regRdData[2]) else $error("clear lost");
   a_pair_match: assert property (rSet ##1 !regWrStrobe ##1 rClr |=> regRdData == $past(regRdData, 2))
      else $error("pair differs");
   a_raw_sticky: assert property (trap ##1 !wSts ##1 rRaw |=> regRdData[2]) else $error("raw not set");
   a_irq_clear: assert property (wSts && !trap |=> !trapIrq) else $error("irq not cleared");
   a_irq_cause: assert property ($rose(trapIrq) |-> $past(trap)) else $error("irq without trap");
   a_irq_hold: assert property (trapIrq && !wSts |=> trapIrq) else $error("irq dropped");
endmodule // ltim_irq_properties
bind ltim_line_trap_irq ltim_irq_properties u_props (.clock(clock), .rstn(rstn), .regAddr(regAddr),
   .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
   .accessValid(accessValid), .accessMode(accessMode), .trapIrq(trapIrq));

// [test/tb_ltim_line_trap_irq.sv]
// testbench for the line-trap interrupt block
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
   $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_ltim_line_trap_irq;
   logic                    clock = 0, rstn = 0, regWrStrobe = 0, regRdStrobe = 0, accessValid = 0, trapIrq;
   logic [7:0]              regAddr = 8'h00;
   logic [31:0]             regWrData = 32'h0, regRdData;
   ltim_pkg::ltim_mode_type accessMode = ltim_pkg::LTIM_MODE_LINEAR;
   int                      err_total = 0, n_tests = 0;
   ltim_line_trap_irq dut (.clock(clock), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
      .accessValid(accessValid), .accessMode(accessMode), .trapIrq(trapIrq));
   initial forever #4 clock = ~clock;
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock); regAddr <= a; regWrData <= d; regWrStrobe <= 1'b1;
      @(posedge clock); regWrStrobe <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock); regAddr <= a; regRdStrobe <= 1'b1;
      @(posedge clock); regRdStrobe <= 1'b0; #1 d = regRdData;
   endtask
   task automatic hit(input logic [1:0] m);
      @(posedge clock); accessValid <= 1'b1; accessMode <= ltim_pkg::ltim_mode_type'(m);
      @(posedge clock); accessValid <= 1'b0; #1;
   endtask
   task automatic t_enable;
      logic [31:0] d;
      rd(8'h08, d); `CHK(d, 32'h0)
      rd(8'h0c, d); `CHK(d, 32'h0)
      wr(8'h08, 32'h0); rd(8'h0c, d); `CHK(d, 32'h0)
      wr(8'h08, 32'h4); rd(8'h0c, d); `CHK(d, 32'h4)
      rd(8'h08, d); `CHK(d, 32'h4)
      rd(8'h0c, d); `CHK(d, 32'h4)
      wr(8'h0c, 32'h0); rd(8'h08, d); `CHK(d, 32'h4)
      wr(8'h10, 32'h4); rd(8'h10, d); `CHK(d, 32'h0)
   endtask
   task automatic t_trap;
      logic [31:0] d;
      for (int m = 0; m < 4; m++) begin
         hit(m[1:0]); `CHK(trapIrq, m[1])
         rd(8'h00, d); `CHK(d[2], m[1])
         rd(8'h04, d); `CHK(d[2], m[1])
         wr(8'h04, 32'h4); rd(8'h04, d); `CHK(d, 32'h0)
         `CHK(trapIrq, 1'b0)
      end
      wr(8'h0c, 32'h4); rd(8'h08, d); `CHK(d, 32'h0)
      hit(2'h3); `CHK(trapIrq, 1'b0)
      rd(8'h00, d); `CHK(d, 32'h4)
      rd(8'h04, d); `CHK(d, 32'h0)
      wr(8'h00, 32'h4); rd(8'h00, d); `CHK(d, 32'h0)
   endtask
   task automatic t_reset;
      logic [31:0] d;
      wr(8'h08, 32'h4); hit(2'h2); `CHK(trapIrq, 1'b1)
      @(posedge clock); rstn <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1; #1;
      `CHK(trapIrq, 1'b0)
      rd(8'h08, d); `CHK(d, 32'h0)
      rd(8'h00, d); `CHK(d, 32'h0)
      rd(8'h04, d); `CHK(d, 32'h0)
   endtask
   task automatic test_done;
      $display("errors %0d checks %0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      t_enable;
      t_trap;
      t_reset;
      test_done;
   end
   initial begin
      repeat (2000) @(posedge clock);
      err_total++;
      test_done;
   end
endmodule // tb_ltim_line_trap_irq
